// ---- design/pzc_top.sv ----
// Function
// - default eight phases; a phase whose sense pin samples high at power-up is off
// - a phase disabled at power-up keeps its drive output off all session
// - phase counts are contiguous; sense pins above N are tied high
// - active phase set is reported on a status output
// - at power-up latch power-saving level and the zone and threshold straps
// - host writes replace strap-derived zone and threshold settings
// - after enable, power-saving changes are ignored until output is nominal
// - power-saving high runs every active phase regardless of load
// - power-saving mid samples load current every 10 us against thresholds
// - threshold disabled at 2 V strap, floating strap, or 0xFF written
// - automatic shedding stays off until output reaches nominal at power-up
// - power-saving low holds fixed zone: boot setting at boot, run setting after
// - low at power-up: run setting only after input leaves low and returns
// - load-line/address strap measured at power-up gives load-line and address
// - strap bins decode to 100%/0% and addresses 0x20, 0x30, 0x40, 0x50
// - host may fine-tune the load-line percentage by register write
// - ramp-supply lockout active only when enabled; input high impedance otherwise
// - zones 0 to 3 continuous conduction, zone 4 discontinuous at 100 kHz
// - eight-phase zones: all, odd outputs, outputs 1 and 5, output 1
`default_nettype none
module pzc_top (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  input  wire logic                 ENABLE,
  input  wire logic                 OUTPUT_AT_NOMINAL,
  input  wire logic [1:0]           POWER_SAVING_INPUT,
  input  wire logic [7:0]           PHASE_CURRENT_SENSE_POS,
  input  wire logic [7:0]           TOTAL_CURRENT_MONITOR,
  input  wire logic [7:0]           FIXED_ZONE_RUN_STRAP,
  input  wire logic [7:0]           FIXED_ZONE_BOOT_STRAP,
  input  wire logic [3:0][7:0]      SHED_THRESHOLD_STRAP,
  input  wire logic [7:0]           LOADLINE_ADDRESS_STRAP,
  input  wire pzc_pkg::pzc_cfg_wr_t CFG_WRITE,
  output logic      [7:0]           PHASE_DRIVE_OUTPUT_EN,
  output logic      [7:0]           PHASE_STATUS,
  output logic      [2:0]           POWER_ZONE,
  output logic                      DCM_100K,
  output logic      [6:0]           LOADLINE_PERCENT,
  output logic      [6:0]           I2C_SLAVE_ADDR,
  output logic                      RAMP_UVLO_EN,
  output logic                      RAMP_INPUT_HIZ,
  output logic                      CONFIG_VALID
);
  localparam int SYNC_W = 76;

  // every pin-side input goes through two stages; straps are static once settled
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync_raw;

  assign sync_raw = {ENABLE, OUTPUT_AT_NOMINAL, POWER_SAVING_INPUT, PHASE_CURRENT_SENSE_POS,
                     TOTAL_CURRENT_MONITOR, FIXED_ZONE_RUN_STRAP, FIXED_ZONE_BOOT_STRAP,
                     SHED_THRESHOLD_STRAP, LOADLINE_ADDRESS_STRAP};

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
    end
  end

  logic            en_s;
  logic            nominal_s;
  logic [1:0]      psi_s;
  logic [7:0]      sense_s;
  logic [7:0]      total_current_monitor_s;
  logic [2:0][7:0] bin_level;
  logic [3:0][7:0] th_level;

  assign {en_s, nominal_s, psi_s, sense_s, total_current_monitor_s, bin_level[0], bin_level[1],
          th_level, bin_level[2]} = sync2_q;

  // index 0 run zone, 1 boot zone, 2 load-line/address
  logic [2:0][2:0] strap_bin;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_bin
      pzc_strap_bin u_bin (
        .level (bin_level[g]),
        .bin   (strap_bin[g])
      );
    end
  endgenerate

  pzc_pkg::pzc_state_t state_q, state_d;
  logic [15:0]       cnt_q, cnt_d;
  pzc_pkg::pzc_cfg_t cfg_q, cfg_d;
  logic [7:0]        active_q, active_d;
  logic [1:0]        psi_boot_q, psi_boot_d;
  logic              armed_q, armed_d;
  logic [2:0]        shed_zone_q, shed_zone_d;
  logic [6:0]        addr_q, addr_d;
  logic [2:0]        zone_req;
  logic [2:0]        zone_eff;
  logic [7:0]        zone_drive;
  logic [7:0]        drive_d;
  logic [2:0]        zone_d;
  logic [7:0]        active_scan;
  logic [2:0]        lpc_run;
  logic [2:0]        lpc_boot;
  logic [2:0]        meas_zone;
  logic              psi_low;
  logic              psi_high;

  assign psi_low  = (psi_s == pzc_pkg::PSI_LOW);
  assign psi_high = (psi_s == pzc_pkg::PSI_HIGH);
  assign lpc_run  = (strap_bin[0] > pzc_pkg::LPC_MAX_BIN) ? pzc_pkg::LPC_MAX_BIN : strap_bin[0];
  assign lpc_boot = (strap_bin[1] > pzc_pkg::LPC_MAX_BIN) ? pzc_pkg::LPC_MAX_BIN : strap_bin[1];

  // a phase counts only if it and every lower phase passed detection
  always_comb begin
    active_scan[0] = ~sense_s[0];
    for (int i = 1; i < pzc_pkg::NUM_PHASES; i++) begin
      active_scan[i] = active_scan[i-1] & ~sense_s[i];
    end
  end

  // unused or disabled thresholds sit at 0xFF, which the 8-bit monitor never exceeds
  always_comb begin
    if (total_current_monitor_s > cfg_q.shed_th[3]) begin
      meas_zone = pzc_pkg::ZONE_ALL;
    end else if (total_current_monitor_s > cfg_q.shed_th[2]) begin
      meas_zone = pzc_pkg::ZONE_HALF;
    end else if (total_current_monitor_s > cfg_q.shed_th[1]) begin
      meas_zone = pzc_pkg::ZONE_QUARTER;
    end else if (total_current_monitor_s > cfg_q.shed_th[0]) begin
      meas_zone = pzc_pkg::ZONE_SINGLE;
    end else begin
      meas_zone = pzc_pkg::ZONE_DCM;
    end
  end

  always_comb begin
    zone_req = pzc_pkg::ZONE_ALL;
    case (state_q)
      pzc_pkg::ST_BOOT: begin
        // the level latched at power-up governs boot; live changes are not looked at
        if (psi_boot_q == pzc_pkg::PSI_LOW) begin
          zone_req = cfg_q.boot_zone;
        end else begin
          zone_req = pzc_pkg::ZONE_ALL;
        end
      end
      pzc_pkg::ST_RUN: begin
        if (psi_high) begin
          zone_req = pzc_pkg::ZONE_ALL;
        end else if (psi_low) begin
          zone_req = armed_q ? cfg_q.run_zone : cfg_q.boot_zone;
        end else begin
          zone_req = shed_zone_q;
        end
      end
      default: begin
        zone_req = pzc_pkg::ZONE_ALL;
      end
    endcase
  end

  pzc_zone_map u_map (
    .active   (active_q),
    .zone_req (zone_req),
    .zone_eff (zone_eff),
    .drive    (zone_drive)
  );

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    cfg_d       = cfg_q;
    active_d    = active_q;
    psi_boot_d  = psi_boot_q;
    armed_d     = armed_q;
    shed_zone_d = shed_zone_q;
    addr_d      = addr_q;
    case (state_q)
      pzc_pkg::ST_SETTLE: begin
        // gives the synchronisers and the strap sources time to settle
        if (cnt_q == 16'(pzc_pkg::SETTLE_CYCLES - 1)) begin
          state_d = pzc_pkg::ST_LATCH;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      pzc_pkg::ST_LATCH: begin
        active_d       = active_scan;
        psi_boot_d     = psi_s;
        armed_d        = ~psi_low;
        cfg_d.run_zone  = lpc_run;
        cfg_d.boot_zone = lpc_boot;
        for (int i = 0; i < 4; i++) begin
          cfg_d.shed_th[i] = (th_level[i] >= pzc_pkg::TH_DISABLE_CODE) ?
                             pzc_pkg::TH_OFF : th_level[i];
        end
        cfg_d.ll = strap_bin[2][0] ? pzc_pkg::LL_NONE : pzc_pkg::LL_FULL;
        addr_d   = 7'(pzc_pkg::ADDR_BASE + 7'(strap_bin[2][2:1]) * pzc_pkg::ADDR_STEP);
        state_d  = pzc_pkg::ST_IDLE;
      end
      pzc_pkg::ST_IDLE: begin
        shed_zone_d = pzc_pkg::ZONE_ALL;
        cnt_d       = '0;
        if (en_s) begin
          state_d = pzc_pkg::ST_BOOT;
        end
      end
      pzc_pkg::ST_BOOT: begin
        if (!en_s) begin
          state_d = pzc_pkg::ST_IDLE;
        end else if (nominal_s) begin
          state_d = pzc_pkg::ST_RUN;
        end
      end
      pzc_pkg::ST_RUN: begin
        if (!en_s) begin
          state_d = pzc_pkg::ST_IDLE;
        end
        if (!psi_low) begin
          armed_d = 1'b1;
        end
        if (psi_s == pzc_pkg::PSI_LOW || psi_high) begin
          // leaving mid restarts shedding from all phases on
          cnt_d       = '0;
          shed_zone_d = pzc_pkg::ZONE_ALL;
        end else if (cnt_q == 16'(pzc_pkg::SHED_CYCLES - 1)) begin
          cnt_d       = '0;
          shed_zone_d = meas_zone;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      default: begin
        state_d = pzc_pkg::ST_SETTLE;
        cnt_d   = '0;
      end
    endcase
    // host writes land after the strap latch, so they also win in the latch cycle
    if (CFG_WRITE.wr && state_q != pzc_pkg::ST_SETTLE) begin
      case (CFG_WRITE.sel)
        pzc_pkg::CFG_SEL_RUN: begin
          cfg_d.run_zone = (CFG_WRITE.data[2:0] > pzc_pkg::LPC_MAX_BIN) ?
                           pzc_pkg::LPC_MAX_BIN : CFG_WRITE.data[2:0];
        end
        pzc_pkg::CFG_SEL_BOOT: begin
          cfg_d.boot_zone = (CFG_WRITE.data[2:0] > pzc_pkg::LPC_MAX_BIN) ?
                            pzc_pkg::LPC_MAX_BIN : CFG_WRITE.data[2:0];
        end
        pzc_pkg::CFG_SEL_LL: begin
          cfg_d.ll = (CFG_WRITE.data > 8'(pzc_pkg::LL_FULL)) ?
                     pzc_pkg::LL_FULL : CFG_WRITE.data[6:0];
        end
        default: begin
          if (CFG_WRITE.sel >= pzc_pkg::CFG_SEL_TH1 && CFG_WRITE.sel <= pzc_pkg::CFG_SEL_TH4) begin
            cfg_d.shed_th[2'(CFG_WRITE.sel - pzc_pkg::CFG_SEL_TH1)] = CFG_WRITE.data;
          end
        end
      endcase
    end
  end

  always_comb begin
    if (state_q == pzc_pkg::ST_BOOT || state_q == pzc_pkg::ST_RUN) begin
      drive_d = zone_drive & active_q;
      zone_d  = zone_eff;
    end else begin
      drive_d = 8'h00;
      zone_d  = pzc_pkg::ZONE_ALL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q          <= pzc_pkg::ST_SETTLE;
      cnt_q            <= '0;
      cfg_q.run_zone   <= pzc_pkg::RST_ZONE;
      cfg_q.boot_zone  <= pzc_pkg::RST_ZONE;
      cfg_q.shed_th    <= {4{pzc_pkg::RST_TH}};
      cfg_q.ll         <= pzc_pkg::RST_LL;
      active_q         <= 8'h00;
      psi_boot_q       <= pzc_pkg::PSI_HIGH;
      armed_q          <= 1'b0;
      shed_zone_q      <= pzc_pkg::ZONE_ALL;
      addr_q           <= pzc_pkg::RST_ADDR;
      PHASE_DRIVE_OUTPUT_EN <= 8'h00;
      PHASE_STATUS     <= 8'h00;
      POWER_ZONE       <= pzc_pkg::ZONE_ALL;
      DCM_100K         <= 1'b0;
      LOADLINE_PERCENT <= pzc_pkg::RST_LL;
      I2C_SLAVE_ADDR   <= pzc_pkg::RST_ADDR;
      RAMP_UVLO_EN     <= 1'b0;
      RAMP_INPUT_HIZ   <= 1'b1;
      CONFIG_VALID     <= 1'b0;
    end else begin
      state_q          <= state_d;
      cnt_q            <= cnt_d;
      cfg_q            <= cfg_d;
      active_q         <= active_d;
      psi_boot_q       <= psi_boot_d;
      armed_q          <= armed_d;
      shed_zone_q      <= shed_zone_d;
      addr_q           <= addr_d;
      PHASE_DRIVE_OUTPUT_EN <= drive_d;
      PHASE_STATUS     <= active_q;
      POWER_ZONE       <= zone_d;
      DCM_100K         <= (zone_d == pzc_pkg::ZONE_DCM);
      LOADLINE_PERCENT <= cfg_q.ll;
      I2C_SLAVE_ADDR   <= addr_q;
      RAMP_UVLO_EN     <= en_s;
      RAMP_INPUT_HIZ   <= ~en_s;
      CONFIG_VALID     <= (state_q != pzc_pkg::ST_SETTLE && state_q != pzc_pkg::ST_LATCH);
    end
  end
endmodule : pzc_top
`default_nettype wire

// ---- design/pzc_pkg.sv ----
`default_nettype none
package pzc_pkg;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          SHED_PERIOD_NS  = 10000;
  localparam int          SHED_CYCLES     = SHED_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          STRAP_SETTLE_NS = 2000;
  localparam int          SETTLE_CYCLES   = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NUM_PHASES      = 8;
  localparam int          CODE_W          = 8;

  // strap levels are 10 mV per code; edges sit midway between resistor bins
  localparam logic [6:0][7:0] BIN_EDGE    = {8'hC6, 8'h81, 8'h5E, 8'h43, 8'h2E, 8'h1E, 8'h11};
  localparam logic [7:0]  TH_DISABLE_CODE = 8'hC8;
  localparam logic [7:0]  TH_OFF          = 8'hFF;
  localparam logic [2:0]  LPC_MAX_BIN     = 3'h4;

  localparam logic [6:0]  LL_FULL         = 7'h64;
  localparam logic [6:0]  LL_NONE         = 7'h00;
  localparam logic [6:0]  ADDR_BASE       = 7'h20;
  localparam logic [6:0]  ADDR_STEP       = 7'h10;

  localparam logic [2:0]  ZONE_ALL        = 3'h0;
  localparam logic [2:0]  ZONE_HALF       = 3'h1;
  localparam logic [2:0]  ZONE_QUARTER    = 3'h2;
  localparam logic [2:0]  ZONE_SINGLE     = 3'h3;
  localparam logic [2:0]  ZONE_DCM        = 3'h4;
  localparam logic [7:0]  MASK_HALF       = 8'h55;
  localparam logic [7:0]  MASK_QUARTER_8  = 8'h11;
  localparam logic [7:0]  MASK_SINGLE     = 8'h01;

  localparam logic [2:0]  CFG_SEL_RUN     = 3'h0;
  localparam logic [2:0]  CFG_SEL_BOOT    = 3'h1;
  localparam logic [2:0]  CFG_SEL_TH1     = 3'h2;
  localparam logic [2:0]  CFG_SEL_TH4     = 3'h5;
  localparam logic [2:0]  CFG_SEL_LL      = 3'h6;

  localparam logic [2:0]  RST_ZONE        = 3'h0;
  localparam logic [7:0]  RST_TH          = 8'hFF;
  localparam logic [6:0]  RST_LL          = 7'h64;
  localparam logic [6:0]  RST_ADDR        = 7'h20;

  typedef enum logic [1:0] {
    PSI_LOW  = 2'b00,
    PSI_MID  = 2'b01,
    PSI_HIGH = 2'b11
  } pzc_psi_t;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b000,
    ST_LATCH  = 3'b001,
    ST_IDLE   = 3'b010,
    ST_BOOT   = 3'b011,
    ST_RUN    = 3'b100
  } pzc_state_t;

  typedef struct packed {
    logic       wr;
    logic [2:0] sel;
    logic [7:0] data;
  } pzc_cfg_wr_t;

  typedef struct packed {
    logic [2:0]      run_zone;
    logic [2:0]      boot_zone;
    logic [3:0][7:0] shed_th;
    logic [6:0]      ll;
  } pzc_cfg_t;
endpackage : pzc_pkg
`default_nettype wire

// ---- design/pzc_strap_bin.sv ----
`default_nettype none
module pzc_strap_bin (
  input  wire logic [7:0] level,
  output logic      [2:0] bin
);
  // nearest resistor bin: count the midpoints the level has passed
  always_comb begin
    bin = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (level >= pzc_pkg::BIN_EDGE[i]) begin
        bin = bin + 3'h1;
      end
    end
  end
endmodule : pzc_strap_bin
`default_nettype wire

// ---- design/pzc_zone_map.sv ----
`default_nettype none
module pzc_zone_map (
  input  wire logic [7:0] active,
  input  wire logic [2:0] zone_req,
  output logic      [2:0] zone_eff,
  output logic      [7:0] drive
);
  logic ph8;
  logic has_quarter;

  always_comb begin
    ph8         = active[7];
    has_quarter = active[7] | (active[5] & ~active[6]) | (active[3] & ~active[4]);
    zone_eff    = pzc_pkg::ZONE_ALL;
    drive       = active;
    // zones a phase count cannot support fall back to all phases
    case (zone_req)
      pzc_pkg::ZONE_ALL: begin
        zone_eff = pzc_pkg::ZONE_ALL;
      end
      pzc_pkg::ZONE_HALF: begin
        if (ph8) begin
          zone_eff = pzc_pkg::ZONE_HALF;
          drive    = pzc_pkg::MASK_HALF & active;
        end
      end
      pzc_pkg::ZONE_QUARTER: begin
        if (has_quarter) begin
          zone_eff = pzc_pkg::ZONE_QUARTER;
          drive    = (ph8 ? pzc_pkg::MASK_QUARTER_8 : pzc_pkg::MASK_HALF) & active;
        end
      end
      pzc_pkg::ZONE_SINGLE: begin
        if (active[1]) begin
          zone_eff = pzc_pkg::ZONE_SINGLE;
          drive    = pzc_pkg::MASK_SINGLE & active;
        end
      end
      default: begin
        zone_eff = pzc_pkg::ZONE_DCM;
        drive    = pzc_pkg::MASK_SINGLE & active;
      end
    endcase
  end
endmodule : pzc_zone_map
`default_nettype wire

// ---- verification/pzc_board_model.sv ----
`default_nettype none
module pzc_board_model (
  input  wire logic       clk,
  input  wire logic       enable,
  input  wire logic [3:0] phase_count,
  input  wire logic [7:0] nominal_delay,
  output logic      [7:0] sense_high,
  output logic            at_nominal
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ramp_q;
  logic [7:0] ramp_d;
  // unused phases have their sense pins strapped to the supply, so they read high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sense_high[i] = (i >= int'(phase_count));
    end
  end
  // output reaches nominal a fixed time after enable; dropping enable restarts the ramp
  always_comb begin
    ramp_d = ramp_q;
    if (!enable) ramp_d = 8'h00;
    else if (ramp_q != nominal_delay) ramp_d = ramp_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    ramp_q <= ramp_d;
  end
  assign at_nominal = enable && (ramp_q == nominal_delay);
endmodule : pzc_board_model
`default_nettype wire

// ---- verification/pzc_top_assertions.sv ----
`default_nettype none
module pzc_top_assertions (
  input wire logic                 CLK_SYS,
  input wire logic                 RST,
  input wire logic                 ENABLE,
  input wire pzc_pkg::pzc_cfg_wr_t CFG_WRITE,
  input wire logic [7:0]           PHASE_DRIVE_OUTPUT_EN,
  input wire logic [7:0]           PHASE_STATUS,
  input wire logic [2:0]           POWER_ZONE,
  input wire logic                 DCM_100K,
  input wire logic [6:0]           LOADLINE_PERCENT,
  input wire logic [6:0]           I2C_SLAVE_ADDR,
  input wire logic                 RAMP_UVLO_EN,
  input wire logic                 RAMP_INPUT_HIZ,
  input wire logic                 CONFIG_VALID
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_ll_write;
    CFG_WRITE.wr && CFG_WRITE.sel == pzc_pkg::CFG_SEL_LL && CFG_WRITE.data <= 8'h64
      && CONFIG_VALID;
  endsequence
  sequence s_ll_shown;
    ##2 LOADLINE_PERCENT == $past(CFG_WRITE.data[6:0], 2);
  endsequence
  sequence s_enable_held;
    $rose(ENABLE) ##1 ENABLE [*4];
  endsequence
  a_drive_within_status: assert property ((PHASE_DRIVE_OUTPUT_EN & ~PHASE_STATUS) == 8'h00)
    else $error("drive enabled on a phase that is not active");
  a_status_contiguous: assert property ((PHASE_STATUS & (PHASE_STATUS + 8'h01)) == 8'h00)
    else $error("active phase set is not contiguous");
  a_straps_held: assert property (CONFIG_VALID && $past(CONFIG_VALID)
      |-> $stable(PHASE_STATUS) && $stable(I2C_SLAVE_ADDR))
    else $error("strap result changed after latch");
  a_dcm_zone_four: assert property (DCM_100K == (POWER_ZONE == pzc_pkg::ZONE_DCM))
    else $error("discontinuous mode flag disagrees with zone");
  a_zone_in_range: assert property (POWER_ZONE <= 3'h4)
    else $error("zone out of range");
  a_ramp_hiz_pair: assert property (RAMP_INPUT_HIZ == !RAMP_UVLO_EN)
    else $error("ramp input impedance and lockout disagree");
  a_uvlo_on_enable: assert property (s_enable_held |-> RAMP_UVLO_EN)
    else $error("ramp lockout not active after enable");
  a_off_when_disabled: assert property (!ENABLE [*8] |-> !RAMP_UVLO_EN
      && PHASE_DRIVE_OUTPUT_EN == 8'h00)
    else $error("drives or lockout active while disabled");
  a_half_zone_mask: assert property (POWER_ZONE == pzc_pkg::ZONE_HALF
      |-> PHASE_DRIVE_OUTPUT_EN == pzc_pkg::MASK_HALF)
    else $error("zone 1 drive pattern wrong");
  a_single_zone_mask: assert property (POWER_ZONE >= pzc_pkg::ZONE_SINGLE
      && PHASE_DRIVE_OUTPUT_EN != 8'h00 |-> PHASE_DRIVE_OUTPUT_EN == pzc_pkg::MASK_SINGLE)
    else $error("single phase zone drive pattern wrong");
  a_loadline_write: assert property (s_ll_write |-> s_ll_shown)
    else $error("load-line write not reflected");
endmodule : pzc_top_assertions
bind pzc_top pzc_top_assertions u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .ENABLE(ENABLE), .CFG_WRITE(CFG_WRITE),
  .PHASE_DRIVE_OUTPUT_EN(PHASE_DRIVE_OUTPUT_EN), .PHASE_STATUS(PHASE_STATUS),
  .POWER_ZONE(POWER_ZONE), .DCM_100K(DCM_100K), .LOADLINE_PERCENT(LOADLINE_PERCENT),
  .I2C_SLAVE_ADDR(I2C_SLAVE_ADDR), .RAMP_UVLO_EN(RAMP_UVLO_EN),
  .RAMP_INPUT_HIZ(RAMP_INPUT_HIZ), .CONFIG_VALID(CONFIG_VALID)
);
`default_nettype wire

// ---- verification/pzc_top_bench.sv ----
`default_nettype none
module pzc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0][7:0] ZMASK = {8'h01, 8'h01, 8'h11, 8'h55, 8'hFF};
  // strap codes sit near, not on, each resistor's nominal level to mimic 1% parts
  localparam logic [7:0][7:0] LLCODE = {8'hF6, 8'h94, 8'h6D, 8'h50, 8'h36, 8'h26, 8'h17, 8'h0A};
  logic                 clk    = 1'b0;
  logic                 rst    = 1'b1;
  logic                 en     = 1'b0;
  logic [1:0]           power_saving_input    = pzc_pkg::PSI_HIGH;
  logic [7:0]           total_current_monitor   = 8'h1E;
  logic [7:0]           run_s  = 8'h26;
  logic [7:0]           boot_s = 8'h36;
  logic [3:0][7:0]      th_s   = {8'hFA, 8'h78, 8'h50, 8'h28};
  logic [7:0]           ll_s   = 8'h0A;
  logic [3:0]           nph    = 4'h8;
  pzc_pkg::pzc_cfg_wr_t cfg    = '0;
  logic [7:0]           sense, drive, status;
  logic                 nominal, dcm, valid, uvlo, hiz;
  logic [2:0]           zone;
  logic [6:0]           llp, addr;
  int                   fails = 0;
  int                   num_checks = 0;
  always #20 clk = ~clk;
  pzc_board_model board (.clk(clk), .enable(en), .phase_count(nph), .nominal_delay(8'h3C),
    .sense_high(sense), .at_nominal(nominal));
  pzc_top dut (.CLK_SYS(clk), .RST(rst), .ENABLE(en), .OUTPUT_AT_NOMINAL(nominal),
    .POWER_SAVING_INPUT(power_saving_input), .PHASE_CURRENT_SENSE_POS(sense), .TOTAL_CURRENT_MONITOR(total_current_monitor),
    .FIXED_ZONE_RUN_STRAP(run_s), .FIXED_ZONE_BOOT_STRAP(boot_s),
    .SHED_THRESHOLD_STRAP(th_s), .LOADLINE_ADDRESS_STRAP(ll_s), .CFG_WRITE(cfg),
    .PHASE_DRIVE_OUTPUT_EN(drive), .PHASE_STATUS(status), .POWER_ZONE(zone),
    .DCM_100K(dcm), .LOADLINE_PERCENT(llp), .I2C_SLAVE_ADDR(addr), .RAMP_UVLO_EN(uvlo),
    .RAMP_INPUT_HIZ(hiz), .CONFIG_VALID(valid));
  task automatic test_done();
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic zchk(input logic [2:0] z);
    @(negedge clk);
    chk({5'h00, zone}, {5'h00, z});
    chk(drive, ZMASK[z]);
    chk({7'h00, dcm}, {7'h00, z == pzc_pkg::ZONE_DCM});
  endtask : zchk
  task automatic power_up(input logic [3:0] n, input logic [7:0] ll, input logic [1:0] p);
    int k = 0;
    @(posedge clk);
    rst <= 1'b1;
    en <= 1'b0;
    nph <= n;
    ll_s <= ll;
    power_saving_input <= p;
    tick(16);
    rst <= 1'b0;
    while (valid !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) begin
      fails++;
      test_done();
    end
  endtask : power_up
  task automatic wait_nom();
    int k = 0;
    while (nominal !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    if (k == 200) begin
      fails++;
      test_done();
    end
  endtask : wait_nom
  task automatic cfg_wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    cfg <= '{wr: 1'b1, sel: s, data: d};
    @(posedge clk);
    cfg <= '{wr: 1'b0, sel: 3'h0, data: 8'h00};
  endtask : cfg_wr
  task automatic shed(input logic [7:0] v, input logic [2:0] z);
    tick(1);
    total_current_monitor <= v;
    // one full sampling period plus sync and output latency
    tick(pzc_pkg::SHED_CYCLES + 10);
    zchk(z);
  endtask : shed
  initial begin
    for (int i = 0; i < 8; i++) begin
      power_up(4'(8 - i), LLCODE[i], pzc_pkg::PSI_HIGH);
      tick(3);
      @(negedge clk);
      chk(status, 8'hFF >> i);
      chk({1'b0, llp}, (i % 2 == 1) ? 8'h00 : 8'h64);
      chk({1'b0, addr}, 8'(8'h20 + 8'h10 * (i / 2)));
      tick(1);
      nph <= 4'h8;
      tick(8);
      @(negedge clk);
      chk(status, 8'hFF >> i);
    end
    power_up(4'h8, 8'h0A, pzc_pkg::PSI_LOW);
    tick(1);
    en <= 1'b1;
    tick(12);
    zchk(3'h3);
    tick(1);
    power_saving_input <= pzc_pkg::PSI_MID;
    tick(6);
    zchk(3'h3);
    tick(1);
    power_saving_input <= pzc_pkg::PSI_LOW;
    wait_nom();
    tick(10);
    zchk(3'h3);
    tick(1);
    power_saving_input <= pzc_pkg::PSI_HIGH;
    tick(10);
    zchk(3'h0);
    tick(1);
    power_saving_input <= pzc_pkg::PSI_LOW;
    tick(10);
    zchk(3'h2);
    // boot setting written above the top zone clamps to the discontinuous zone
    cfg_wr(pzc_pkg::CFG_SEL_BOOT, 8'h07);
    tick(1);
    en <= 1'b0;
    tick(8);
    @(negedge clk);
    chk(drive, 8'h00);
    chk({6'h00, uvlo, hiz}, 8'h01);
    tick(1);
    en <= 1'b1;
    tick(12);
    zchk(3'h4);
    power_up(4'h8, 8'h0A, pzc_pkg::PSI_MID);
    tick(1);
    en <= 1'b1;
    tick(12);
    zchk(3'h0);
    chk({6'h00, uvlo, hiz}, 8'h02);
    wait_nom();
    shed(8'h1E, 3'h4);
    shed(8'h3C, 3'h3);
    shed(8'h64, 3'h2);
    shed(8'h82, 3'h1);
    shed(8'hFF, 3'h1);
    cfg_wr(pzc_pkg::CFG_SEL_TH4, 8'h8C);
    shed(8'hFF, 3'h0);
    cfg_wr(3'h4, 8'hFF);
    shed(8'h82, 3'h2);
    cfg_wr(pzc_pkg::CFG_SEL_LL, 8'h32);
    tick(2);
    @(negedge clk);
    chk({1'b0, llp}, 8'h32);
    cfg_wr(pzc_pkg::CFG_SEL_LL, 8'h78);
    tick(2);
    @(negedge clk);
    chk({1'b0, llp}, 8'h64);
    // armed at power-up by the mid level, so low now selects the written run zone
    cfg_wr(pzc_pkg::CFG_SEL_RUN, 8'h01);
    tick(1);
    power_saving_input <= pzc_pkg::PSI_LOW;
    tick(10);
    zchk(3'h1);
    test_done();
  end
endmodule : pzc_top_bench
`default_nettype wire
